// ### tcsc_ctrl.sv
// type-c source (downstream-facing) cc controller core
// assumes cc comparators, level decoder and vbus comparator outputs are
// synchronous to clk; analog pull-ups take the rp_strength code
//
// What this block does
// - pull-ups on both cc lines are enabled with strength from the select input.
// - a low or floating select advertises default usb current (500 ma / 900 ma).
// - mid select advertises 1.5 a and high select advertises 3 a.
// - a valid attach on cc1 drives the orientation output low.
// - a valid attach on cc2 releases the orientation output so it reads high.
// - the orientation output is open drain, only pulling low or releasing.
// - after reset the port is unattached until an attach succeeds.
// - while unattached both cc lines are watched continuously for a sink.
// - unattached covers the idle and attach-wait states; active is attached.
// - while active the open-drain attach indicator is asserted.
// - unplug returns the port to unattached and releases the attach indicator.
// - vbus presence comes from the vbus sense input.
// - a cc attach is debounced for 168 ms before the port is attached.
// - the vbus sense input is debounced for 2 ms before vbus counts as present.
`timescale 1ns/100ps
`include "tcsc_consts.svh"

module tcsc_ctrl
#(
    parameter int unsigned ATTACH_DB_CYC = `TCSC_ATTACH_DB_CYC,
    parameter int unsigned VBUS_DB_CYC = `TCSC_VBUS_DB_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // cc comparators and current select
    input wire tcsc_pkg::tcsc_cc_type cc_sense,
    input wire logic [1:0] current_sel,
    // vbus sense
    input wire logic vbus_sense_in,
    // analog pull-up control
    output logic rp_enable,
    output logic [1:0] rp_strength,
    // open-drain outputs
    output tcsc_pkg::tcsc_od_type attach_indicator,
    output tcsc_pkg::tcsc_od_type orientation,
    // status
    output logic vbus_present
);

    // ==========================================================
    // state
    typedef struct packed
    {
        // port mode
        tcsc_pkg::tcsc_state_type state;
        // attach debounce count
        logic [31:0] attach_cnt;
        // vbus debounce count
        logic [31:0] vbus_cnt;
        // debounced vbus
        logic vbus_ok;
        // advertised pull-up code
        logic [1:0] strength;
        // side seen at first detect
        logic cc2_side;
        // attach indicator pull
        logic ind_oe;
        // orientation pull
        logic dir_oe;
        // pull-up enable
        logic rp_en;
    } tcsc_regs_type;

    tcsc_regs_type r;
    tcsc_regs_type next_r;

    // ==========================================================
    // helpers
    // last count of each debounce window, cut to the counter width
    localparam logic [31:0] ATTACH_LAST = 32'(ATTACH_DB_CYC - 1);
    localparam logic [31:0] VBUS_LAST = 32'(VBUS_DB_CYC - 1);

    function automatic logic [1:0] tcsc_decode(input logic [1:0] sel);
        logic [1:0] code;
        code = `TCSC_RP_DEFAULT;
        // code 3 falls back to default, like a floating pin
        case (sel)
            `TCSC_SEL_LOW: code = `TCSC_RP_DEFAULT;
            `TCSC_SEL_MID: code = `TCSC_RP_MED;
            `TCSC_SEL_HIGH: code = `TCSC_RP_HIGH;
            default: code = `TCSC_RP_DEFAULT;
        endcase
        return code;
    endfunction : tcsc_decode

    // window end test shared by both debounce counters
    function automatic logic tcsc_done(input logic [31:0] cnt, input logic [31:0] last);
        logic done;
        done = (cnt >= last);
        return done;
    endfunction : tcsc_done

    // saturating step, so a counter never wraps into a short window
    function automatic logic [31:0] tcsc_step(input logic [31:0] cnt);
        logic [31:0] nxt;
        nxt = cnt;
        if (cnt != 32'hffffffff)
        begin
            nxt = cnt + 32'h1;
        end
        return nxt;
    endfunction : tcsc_step

    // one line valid, and on the side seen first
    function automatic logic tcsc_same_side(input tcsc_pkg::tcsc_cc_type cc, input logic side);
        logic same;
        same = (cc.cc1_valid ^ cc.cc2_valid) && (cc.cc2_valid == side);
        return same;
    endfunction : tcsc_same_side

    // ==========================================================
    // cc line view
    logic cc_any;
    logic cc_one;
    logic cc_keep;
    // both lines gone is the only unplug
    assign cc_any = cc_sense.cc1_valid | cc_sense.cc2_valid;
    // exactly one line valid marks a sink; both valid is ignored
    assign cc_one = cc_sense.cc1_valid ^ cc_sense.cc2_valid;
    // same sink still seen on the same side
    assign cc_keep = tcsc_same_side(cc_sense, r.cc2_side);

    // ==========================================================
    // next state
    always_comb
    begin
        next_r = r;
        next_r.rp_en = 1'b1;

        // ==========================================================
        // vbus debounce
        // vbus debounce
        if (!vbus_sense_in)
        begin
            // any low sample restarts the window
            next_r.vbus_cnt = 32'h0;
            next_r.vbus_ok = 1'b0;
        end
        else if (tcsc_done(r.vbus_cnt, VBUS_LAST))
        begin
            next_r.vbus_cnt = r.vbus_cnt;
            next_r.vbus_ok = 1'b1;
        end
        else
        begin
            next_r.vbus_cnt = tcsc_step(r.vbus_cnt);
            next_r.vbus_ok = 1'b0;
        end

        // ==========================================================
        // port state
        unique case (r.state)
            tcsc_pkg::tcsc_unattached:
            begin
                next_r.strength = tcsc_decode(current_sel);
                next_r.ind_oe = 1'b0;
                // orientation keeps the last attach until the next one
                next_r.dir_oe = r.dir_oe;
                next_r.attach_cnt = 32'h0;
                if (cc_one)
                begin
                    next_r.state = tcsc_pkg::tcsc_attach_wait;
                    next_r.cc2_side = cc_sense.cc2_valid;
                end
                else
                begin
                    next_r.state = tcsc_pkg::tcsc_unattached;
                    next_r.cc2_side = r.cc2_side;
                end
            end

            tcsc_pkg::tcsc_attach_wait:
            begin
                next_r.strength = tcsc_decode(current_sel);
                next_r.cc2_side = r.cc2_side;
                next_r.dir_oe = r.dir_oe;
                // restart on loss or side change
                if (!cc_keep)
                begin
                    next_r.state = tcsc_pkg::tcsc_unattached;
                    next_r.ind_oe = 1'b0;
                    next_r.attach_cnt = 32'h0;
                end
                else if (tcsc_done(r.attach_cnt, ATTACH_LAST))
                begin
                    next_r.state = tcsc_pkg::tcsc_attached;
                    next_r.ind_oe = 1'b1;
                    next_r.dir_oe = ~r.cc2_side;
                    next_r.attach_cnt = r.attach_cnt;
                end
                else
                begin
                    next_r.state = tcsc_pkg::tcsc_attach_wait;
                    next_r.ind_oe = 1'b0;
                    next_r.attach_cnt = tcsc_step(r.attach_cnt);
                end
            end

            tcsc_pkg::tcsc_attached:
            begin
                next_r.strength = r.strength;
                next_r.cc2_side = r.cc2_side;
                next_r.dir_oe = r.dir_oe;
                next_r.attach_cnt = 32'h0;
                if (!cc_any)
                begin
                    next_r.state = tcsc_pkg::tcsc_unattached;
                    next_r.ind_oe = 1'b0;
                end
                else
                begin
                    // one line dropping alone is not an unplug
                    next_r.state = tcsc_pkg::tcsc_attached;
                    next_r.ind_oe = 1'b1;
                end
            end

            default:
            begin
                // unused code: fall back to a safe released port
                next_r.state = tcsc_pkg::tcsc_unattached;
                next_r.strength = `TCSC_RP_DEFAULT;
                next_r.ind_oe = 1'b0;
                next_r.dir_oe = 1'b0;
                next_r.attach_cnt = 32'h0;
            end
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // reset to unattached
            // pins released and pull-ups off while held
            r.state <= tcsc_pkg::tcsc_unattached;
            r.attach_cnt <= 32'h0;
            r.vbus_cnt <= 32'h0;
            r.vbus_ok <= 1'b0;
            r.strength <= `TCSC_RP_DEFAULT;
            r.cc2_side <= 1'b0;
            r.ind_oe <= 1'b0;
            r.dir_oe <= 1'b0;
            r.rp_en <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ==========================================================
    // outputs, all straight from flip-flops
    // open drain, never driven high
    function automatic tcsc_pkg::tcsc_od_type tcsc_od(input logic pull);
        tcsc_pkg::tcsc_od_type pin;
        pin.out = 1'b0;
        pin.oe = pull;
        return pin;
    endfunction : tcsc_od

    // ==========================================================
    // pull-up control
    assign rp_enable = r.rp_en;
    assign rp_strength = r.strength;

    // ==========================================================
    // open-drain pins
    // orientation pull
    assign orientation = tcsc_od(r.dir_oe);
    assign attach_indicator = tcsc_od(r.ind_oe);

    // ==========================================================
    // status
    assign vbus_present = r.vbus_ok;

endmodule : tcsc_ctrl

// ### tcsc_consts.svh
// timing counts, encodings and reset values for the type-c source cc block
// assumes a 100 mhz clock and synchronous pin inputs
`ifndef TCSC_CONSTS_SVH
`define TCSC_CONSTS_SVH

// ==========================================================
// clock and timing
`define TCSC_CLK_MHZ 100
`define TCSC_ATTACH_DB_MS 168
`define TCSC_VBUS_DB_MS 2
`define TCSC_ATTACH_DB_CYC (`TCSC_ATTACH_DB_MS * 1000 * `TCSC_CLK_MHZ)
`define TCSC_VBUS_DB_CYC (`TCSC_VBUS_DB_MS * 1000 * `TCSC_CLK_MHZ)

// ==========================================================
// current level select encoding (two-bit level from the pad comparator)
`define TCSC_SEL_LOW 2'h0
`define TCSC_SEL_MID 2'h1
`define TCSC_SEL_HIGH 2'h2

// ==========================================================
// pull-up strength codes driven to the analog current sources
`define TCSC_RP_DEFAULT 2'h1
`define TCSC_RP_MED 2'h2
`define TCSC_RP_HIGH 2'h3

`endif

// ### tcsc_pkg.sv
// types shared by the type-c source cc block
// assumes tcsc_consts.svh for numeric values
package tcsc_pkg;

    // ==========================================================
    // port states, gray coded along unattached -> wait -> attached
    typedef enum logic [1:0]
    {
        tcsc_unattached = 2'h0,
        tcsc_attach_wait = 2'h1,
        tcsc_attached = 2'h3
    } tcsc_state_type;

    // ==========================================================
    // cc line comparator results
    typedef struct packed
    {
        logic cc1_valid;
        logic cc2_valid;
    } tcsc_cc_type;

    // ==========================================================
    // open-drain pin drive: low while enabled
    typedef struct packed
    {
        logic out;
        logic oe;
    } tcsc_od_type;

endpackage : tcsc_pkg

// ### tcsc_ctrl_assertions.sv
// port checks for tcsc_ctrl
// assumes bind from tb, single clock domain
`timescale 1ns/100ps
module tcsc_ctrl_chk
#(
    parameter int unsigned ATTACH_DB_CYC = 20,
    parameter int unsigned VBUS_DB_CYC = 10
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire tcsc_pkg::tcsc_cc_type cc_sense,
    input wire logic [1:0] current_sel,
    input wire logic vbus_sense_in,
    input wire logic rp_enable,
    input wire logic [1:0] rp_strength,
    input wire tcsc_pkg::tcsc_od_type attach_indicator,
    input wire tcsc_pkg::tcsc_od_type orientation,
    input wire logic vbus_present
);
    // ==========================================================
    // run lengths: debounce windows judged on a plus-one slack
    logic [1:0] prev_cc;
    int run;
    int vrun;
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
        begin
            prev_cc <= 2'h0;
            run <= 0;
            vrun <= 0;
        end
        else
        begin
            prev_cc <= cc_sense;
            run <= (^cc_sense && cc_sense == prev_cc) ? run + 1 : 0;
            vrun <= vbus_sense_in ? vrun + 1 : 0;
        end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_unplug; attach_indicator.oe && !cc_sense; endsequence
    sequence s_idle2; !attach_indicator.oe ##1 !attach_indicator.oe; endsequence
    property p_rp_on; $past(reset_n) |-> rp_enable; endproperty
    property p_od; !attach_indicator.out && !orientation.out; endproperty
    property p_orient;
        $rose(attach_indicator.oe) |-> orientation.oe == $past(cc_sense.cc1_valid);
    endproperty
    property p_db; $rose(attach_indicator.oe) |-> run inside {[ATTACH_DB_CYC:ATTACH_DB_CYC + 1]};
    endproperty
    property p_unplug; s_unplug |=> !attach_indicator.oe; endproperty
    property p_hold_off; !attach_indicator.oe && !$stable(cc_sense) |=> !attach_indicator.oe;
    endproperty
    property p_sel_held; attach_indicator.oe && $past(attach_indicator.oe) |-> $stable(rp_strength);
    endproperty
    property p_sel_map;
        s_idle2 |-> rp_strength == ($past(current_sel) == 2'h1 ? 2'h2 :
            $past(current_sel) == 2'h2 ? 2'h3 : 2'h1);
    endproperty
    property p_vbus_off; !vbus_sense_in |=> !vbus_present; endproperty
    property p_vbus_db; $rose(vbus_present) |-> vrun inside {[VBUS_DB_CYC:VBUS_DB_CYC + 1]};
    endproperty
    a_rp_on: assert property (p_rp_on) else $error("pull-up off");
    a_od: assert property (p_od) else $error("open drain driven high");
    a_orient: assert property (p_orient) else $error("orientation");
    a_db: assert property (p_db) else $error("attach debounce");
    a_unplug: assert property (p_unplug) else $error("detach");
    a_hold_off: assert property (p_hold_off) else $error("early attach");
    a_sel_held: assert property (p_sel_held) else $error("strength moved");
    a_sel_map: assert property (p_sel_map) else $error("strength map");
    a_vbus_off: assert property (p_vbus_off) else $error("vbus stuck");
    a_vbus_db: assert property (p_vbus_db) else $error("vbus debounce");
endmodule : tcsc_ctrl_chk

// ### tcsc_sink.sv
// sink model presenting pull-downs on the cc lines
// assumes mode and chatter come from the bench
`timescale 1ns/100ps
module tcsc_sink
(
    // clock; mode 0 none, 1 cc1, 2 cc2, 3 both
    input wire logic clk,
    input wire logic [1:0] mode,
    input wire logic chatter,
    // comparator view
    output tcsc_pkg::tcsc_cc_type cc_sense
);
    // ==========================================================
    // chatter flips sides each cycle, like a plug being wiggled
    initial cc_sense = 2'h0;
    always @(negedge clk)
        cc_sense <= chatter ? {~cc_sense.cc1_valid, cc_sense.cc1_valid} : {mode[0], mode[1]};
endmodule : tcsc_sink

// ### tb.sv
// self-checking bench for tcsc_ctrl with a sink model
// assumes shortened debounce counts
`timescale 1ns/100ps
module tb;
    localparam int unsigned ATTACH_DB_CYC = 20;
    localparam int unsigned VBUS_DB_CYC = 10;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] mode = 2'h0;
    logic chatter = 1'b0;
    logic [1:0] current_sel = 2'h0;
    logic vbus_sense_in = 1'b0;
    logic rp_enable;
    logic [1:0] rp_strength;
    logic vbus_present;
    tcsc_pkg::tcsc_cc_type cc_sense;
    tcsc_pkg::tcsc_od_type attach_indicator;
    tcsc_pkg::tcsc_od_type orientation;
    logic q[$];
    logic was_on = 1'b0;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'h54b2f33c;
    tcsc_sink sink_u (.clk, .mode, .chatter, .cc_sense);
    tcsc_ctrl #(.ATTACH_DB_CYC(ATTACH_DB_CYC), .VBUS_DB_CYC(VBUS_DB_CYC)) dut_u (.clk, .reset_n,
        .cc_sense, .current_sel, .vbus_sense_in, .rp_enable, .rp_strength, .attach_indicator,
        .orientation, .vbus_present);
    task automatic chk(input string nm, input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    initial forever #5 clk = ~clk;
    always @(posedge clk)
        if (++cycles == 3000)
        begin
            n_fail++;
            stop_test();
        end
    // ==========================================================
    // orientation note taken off the queue at each attach
    always @(negedge clk)
    begin
        if (attach_indicator.oe === 1'b1 && !was_on)
            if (q.size() == 0)
                chk("attach", 2'h1, 2'h0);
            else
                chk("orientation", {1'b0, orientation.oe}, {1'b0, q.pop_front()});
        was_on <= attach_indicator.oe === 1'b1;
    end
    initial
    begin
        cyc(12);
        reset_n = 1'b1;
        cyc(2);
        chk("rp_enable", {1'b0, rp_enable}, 2'h1);
        for (int s = 0; s < 4; s++)
        begin
            current_sel = 2'(s);
            cyc(2);
            chk("strength", rp_strength, s == 1 ? 2'h2 : s == 2 ? 2'h3 : 2'h1);
        end
        for (int side = 1; side < 3; side++)
        begin
            current_sel = 2'h2;
            mode = 2'(side);
            q.push_back(side == 1);
            cyc(ATTACH_DB_CYC - 2);
            chk("wait", {1'b0, attach_indicator.oe}, 2'h0);
            cyc(5);
            chk("attached", {1'b0, attach_indicator.oe}, 2'h1);
            current_sel = 2'h1;
            cyc(2);
            chk("held", rp_strength, 2'h3);
            mode = 2'h0;
            cyc(3);
            chk("unplug", {1'b0, attach_indicator.oe}, 2'h0);
        end
        chatter = 1'b1;
        cyc(3 * ATTACH_DB_CYC);
        chatter = 1'b0;
        mode = 2'h3;
        cyc(3 * ATTACH_DB_CYC);
        chk("both", {1'b0, attach_indicator.oe}, 2'h0);
        mode = 2'h0;
        repeat (4)
        begin
            vbus_sense_in = 1'b1;
            cyc(1 + ($unsigned($random(seed)) % (VBUS_DB_CYC - 2)));
            vbus_sense_in = 1'b0;
            cyc(2);
            chk("vbus glitch", {1'b0, vbus_present}, 2'h0);
        end
        vbus_sense_in = 1'b1;
        cyc(VBUS_DB_CYC + 3);
        chk("vbus", {1'b0, vbus_present}, 2'h1);
        vbus_sense_in = 1'b0;
        cyc(2);
        chk("vbus off", {1'b0, vbus_present}, 2'h0);
        chk("notes left", 2'(q.size()), 2'h0);
        stop_test();
    end
endmodule : tb
bind tcsc_ctrl tcsc_ctrl_chk #(.ATTACH_DB_CYC(ATTACH_DB_CYC), .VBUS_DB_CYC(VBUS_DB_CYC)) chk_u
    (.clk, .reset_n, .cc_sense, .current_sel, .vbus_sense_in, .rp_enable, .rp_strength,
    .attach_indicator, .orientation, .vbus_present);
